// [src/psf_pkg.sv]
// Purpose: Shared constants and types for the sequencing and fault registers
// Assumes: 25 MHz core clock, two paged outputs
// Notes: Command codes are the byte values sent on the management port
package psf_pkg;
    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_IIN_OC_LIMIT = 8'h5B;
    localparam logic [7:0] CMD_ON_DLY = 8'h60;
    localparam logic [7:0] CMD_TON_RAMP = 8'h61;
    localparam logic [7:0] CMD_OFF_DLY = 8'h64;
    localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
    localparam logic [7:0] CMD_FAULT_SUMMARY = 8'h78;
    // ****************************************************************
    // Reset values and accepted ranges
    // ****************************************************************
    localparam logic [15:0] RST_IIN_OC_LIMIT = 16'h0032;
    localparam logic [15:0] RST_ON_DLY = 16'h0014;
    localparam logic [15:0] RST_TON_RAMP = 16'h01F4;
    localparam logic [15:0] RST_OFF_DLY = 16'h0000;
    localparam logic [15:0] RST_TOFF_RAMP = 16'h01F4;
    localparam logic [7:0] RST_SUMMARY = 8'h40;
    localparam logic [15:0] IIN_OC_MAX = 16'h0032;
    localparam logic [15:0] ON_DLY_MIN = 16'h0014;
    localparam logic [15:0] RAMP_MAX = 16'h2710;
    localparam logic [15:0] OFF_DLY_MAX = 16'h2710;
    // ****************************************************************
    // Fault summary bit positions
    // ****************************************************************
    localparam int FS_UNUSED = 7;
    localparam int FS_OFF = 6;
    localparam int FS_OV = 5;
    localparam int FS_OC = 4;
    localparam int FS_VIN_UV = 3;
    localparam int FS_TEMP = 2;
    localparam int FS_COMM = 1;
    localparam int FS_OTHER = 0;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int US_NS = 1000;
    localparam int DELAY_UNIT_US = 10;
    localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W = $clog2(CYC_PER_US);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
    localparam int TIME_W = 20;
    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        SEQ_OFF, SEQ_ON_WAIT, SEQ_RISE, SEQ_ON, SEQ_OFF_WAIT, SEQ_FALL
    } psf_seq_e;
endpackage

// [src/psf_seq_if.sv]
// Purpose: Settings and state between register bank and one sequencer
// Assumes: One instance per output
// Notes: Ramp values arriving here are already the committed copies
`timescale 1ns/1ps
interface psf_seq_if;
    import psf_pkg::*;
    logic enable;
    logic [15:0] on_delay;
    logic [15:0] on_ramp;
    logic [15:0] off_delay;
    logic [15:0] off_ramp;
    psf_seq_e state;
    logic powered;
    modport ctrl (output enable, on_delay, on_ramp, off_delay, off_ramp,
        input state, powered);
    modport seq (input enable, on_delay, on_ramp, off_delay, off_ramp,
        output state, powered);
endinterface

// [src/psf_seq.sv]
// Purpose: Turn-on and turn-off timing for one output
// Assumes: Delay counts are 10 us each, ramp counts 1 us each
// Notes: Elapsed time restarts on every state change
`timescale 1ns/1ps
module psf_seq
    import psf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    psf_seq_if.seq link
);
    logic [PRE_W-1:0] pre_reg;
    logic [TIME_W-1:0] cnt_reg;
    logic [TIME_W-1:0] target;
    psf_seq_e state_reg;
    psf_seq_e state_next;
    logic done;

    // Scale a register count to microseconds
    function automatic logic [TIME_W-1:0] to_us(input logic [15:0] v,
        input logic x10);
        logic [TIME_W-1:0] w;
        w = {4'h0, v};
        to_us = x10 ? TIME_W'(w * DELAY_UNIT_US) : w;
    endfunction

    // Time to spend in the current state
    always_comb
    begin
        case (state_reg)
            SEQ_ON_WAIT: target = to_us(link.on_delay, 1'b1);
            SEQ_RISE: target = to_us(link.on_ramp, 1'b0);
            SEQ_OFF_WAIT: target = to_us(link.off_delay, 1'b1);
            SEQ_FALL: target = to_us(link.off_ramp, 1'b0);
            default: target = '0;
        endcase
    end
    assign done = cnt_reg >= target;

    // Delay, ramp, hold, then the reverse on disable
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SEQ_OFF: if (link.enable) state_next = SEQ_ON_WAIT; // RQ13
            SEQ_ON_WAIT:
                if (!link.enable) state_next = SEQ_OFF;
                else if (done) state_next = SEQ_RISE; // RQ13
            SEQ_RISE:
                if (!link.enable) state_next = SEQ_OFF_WAIT;
                else if (done) state_next = SEQ_ON; // RQ13
            SEQ_ON: if (!link.enable) state_next = SEQ_OFF_WAIT; // RQ13
            SEQ_OFF_WAIT:
                if (link.enable) state_next = SEQ_ON;
                else if (done) state_next = SEQ_FALL; // RQ13
            SEQ_FALL:
                if (link.enable) state_next = SEQ_ON_WAIT;
                else if (done) state_next = SEQ_OFF; // RQ13
            default: state_next = SEQ_OFF;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst) state_reg <= SEQ_OFF;
        else state_reg <= state_next;
    end

    // Microsecond prescaler and elapsed time
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || state_next != state_reg)
        begin
            pre_reg <= '0;
            cnt_reg <= '0;
        end
        else if (pre_reg == PRE_LAST)
        begin
            pre_reg <= '0;
            cnt_reg <= cnt_reg + TIME_W'(1);
        end
        else pre_reg <= pre_reg + PRE_W'(1);
    end

    assign link.state = state_reg;
    assign link.powered = state_reg != SEQ_OFF && state_reg != SEQ_ON_WAIT;

    a_rise_after_dly: assert property (@(posedge sys_clk) // RQ13
        disable iff (sys_rst)
        (state_reg == SEQ_ON_WAIT && state_next == SEQ_RISE)
        |-> cnt_reg >= to_us(link.on_delay, 1'b1))
        else $error("rise began before turn-on delay");
    a_fall_after_dly: assert property (@(posedge sys_clk) // RQ13
        disable iff (sys_rst)
        (state_reg == SEQ_OFF_WAIT && state_next == SEQ_FALL)
        |-> cnt_reg >= to_us(link.off_delay, 1'b1))
        else $error("fall began before turn-off delay");
endmodule

// [src/psf_fault.sv]
// Purpose: Global fault summary byte for both outputs
// Assumes: Fault inputs are levels from the detailed status logic
// Notes: Registered, one cycle behind its sources
`timescale 1ns/1ps
module psf_fault
    import psf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] powered,
    input wire logic [1:0] ov,
    input wire logic [1:0] oc,
    input wire logic vin_uv,
    input wire logic temp,
    input wire logic comm,
    input wire logic other,
    output logic [7:0] summary_reg
);
    logic [7:0] summary_next;

    // Either output's condition is reported in the shared byte
    always_comb
    begin
        summary_next = 8'h00; // RQ9
        summary_next[FS_UNUSED] = 1'b0; // RQ10
        summary_next[FS_OFF] = ~&powered; // RQ10
        summary_next[FS_OV] = |ov; // RQ11
        summary_next[FS_OC] = |oc; // RQ11
        summary_next[FS_VIN_UV] = vin_uv; // RQ11
        summary_next[FS_TEMP] = temp; // RQ12
        summary_next[FS_COMM] = comm; // RQ12
        summary_next[FS_OTHER] = other; // RQ12
    end

    // Summary register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst) summary_reg <= RST_SUMMARY;
        else summary_reg <= summary_next;
    end
endmodule

// [src/psf_regs.sv]
// Purpose: Command register bank for sequencing timing and fault summary
// Assumes: Command port decoded by the serial front end, one cycle a command
// Notes: Ramp times and input current limit take effect on commit
`timescale 1ns/1ps
// Function
// [RQ1] Input current limit: 16-bit amps, reset 50, 0..50, used after commit.
// [RQ2] Turn-on delay resets to 20 counts, meaning 200 us.
// [RQ3] Turn-on delay count is 10 us, usable 200 us to 655,340 us; the code accepts up to 65535 counts, 655,350 us.
// [RQ4] Turn-on ramp: 1 us per count, 0 to 10,000, reset 500.
// [RQ5] Host commits after changing turn-on ramp or output voltage target.
// [RQ6] Turn-off delay: 10 us per count, up to 100,000 us, reset 0.
// [RQ7] Turn-off ramp: 1 us per count, 0 to 10,000, reset 500.
// [RQ8] Host commits after changing turn-off ramp or output voltage target.
// [RQ9] Fault summary is global, read-only, covers both outputs.
// [RQ10] Bit 6 set when an output gives no power; bit 7 reads zero.
// [RQ11] Bit 5 output overvoltage, 4 output overcurrent, 3 input undervoltage.
// [RQ12] Bits 2, 1, 0: temperature, comm/memory/logic, any other change.
// [RQ13] Sequencer waits delay then ramps on enable; reverse on disable.
// [RQ14] Commit-type writes sit in a shadow until the commit command.
module psf_regs
    import psf_pkg::*;
#(
    parameter int OUTPUTS = 2
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_page,
    input wire logic [15:0] cmd_wdata,
    input wire logic commit_settings_command,
    input wire logic clear_faults,
    input wire logic [1:0] out_enable,
    input wire logic [1:0] output_overvoltage_flag,
    input wire logic [1:0] output_overcurrent_flag,
    input wire logic input_undervoltage_flag,
    input wire logic temperature_flag,
    input wire logic other_status_flag,
    output logic [15:0] rd_data_reg,
    output logic rd_valid_reg,
    output logic comm_memory_logic_flag_reg,
    output logic [15:0] iin_oc_active_reg,
    output logic [1:0] out_powered_reg,
    output logic [1:0] out_rising_reg,
    output logic [1:0] out_falling_reg
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [15:0] iin_oc_shadow_reg;
    logic [15:0] on_delay_reg [OUTPUTS];
    logic [15:0] off_delay_reg [OUTPUTS];
    logic [15:0] on_ramp_sh_reg [OUTPUTS];
    logic [15:0] on_ramp_act_reg [OUTPUTS];
    logic [15:0] off_ramp_sh_reg [OUTPUTS];
    logic [15:0] off_ramp_act_reg [OUTPUTS];
    logic [7:0] summary;
    logic [1:0] powered;
    logic [1:0] rising;
    logic [1:0] falling;
    logic wr_go;
    logic bad_go;
    logic [15:0] rd_data_next;

    // Known command codes
    function automatic logic known(input logic [7:0] c);
        known = c == CMD_IIN_OC_LIMIT || c == CMD_ON_DLY
            || c == CMD_TON_RAMP || c == CMD_OFF_DLY
            || c == CMD_TOFF_RAMP || c == CMD_FAULT_SUMMARY;
    endfunction

    // Range check of a write; read-only targets never pass
    function automatic logic write_ok(input logic [7:0] c,
        input logic [15:0] d);
        case (c)
            CMD_IIN_OC_LIMIT: write_ok = d <= IIN_OC_MAX; // RQ1
            CMD_ON_DLY: write_ok = d >= ON_DLY_MIN; // RQ3
            CMD_TON_RAMP: write_ok = d <= RAMP_MAX; // RQ4
            CMD_OFF_DLY: write_ok = d <= OFF_DLY_MAX; // RQ6
            CMD_TOFF_RAMP: write_ok = d <= RAMP_MAX; // RQ7
            default: write_ok = 1'b0; // RQ9
        endcase
    endfunction

    // Accepted writes and refused commands
    assign wr_go = cmd_valid && cmd_write && write_ok(cmd_code, cmd_wdata);
    assign bad_go = cmd_valid && (cmd_write ? !write_ok(cmd_code, cmd_wdata)
        : !known(cmd_code));

    // ****************************************************************
    // Global input current limit, shadow then active
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst) iin_oc_shadow_reg <= RST_IIN_OC_LIMIT; // RQ1
        else if (wr_go && cmd_code == CMD_IIN_OC_LIMIT)
            iin_oc_shadow_reg <= cmd_wdata; // RQ14
    end

    // Active limit moves only on commit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst) iin_oc_active_reg <= RST_IIN_OC_LIMIT;
        else if (commit_settings_command)
            iin_oc_active_reg <= iin_oc_shadow_reg; // RQ1
    end

    // ****************************************************************
    // Paged timing registers and sequencers
    // ****************************************************************
    for (genvar i = 0; i < OUTPUTS; i++)
    begin : g_out
        logic sel;
        psf_seq_if link ();
        assign sel = wr_go && cmd_page == 1'(i);

        // Delays act at once
        always_ff @(posedge sys_clk)
        begin
            if (sys_rst)
            begin
                on_delay_reg[i] <= RST_ON_DLY; // RQ2
                off_delay_reg[i] <= RST_OFF_DLY; // RQ6
            end
            else if (sel && cmd_code == CMD_ON_DLY)
                on_delay_reg[i] <= cmd_wdata; // RQ3
            else if (sel && cmd_code == CMD_OFF_DLY)
                off_delay_reg[i] <= cmd_wdata; // RQ6
        end

        // Ramp shadows take writes
        always_ff @(posedge sys_clk)
        begin
            if (sys_rst)
            begin
                on_ramp_sh_reg[i] <= RST_TON_RAMP; // RQ4
                off_ramp_sh_reg[i] <= RST_TOFF_RAMP; // RQ7
            end
            else if (sel && cmd_code == CMD_TON_RAMP)
                on_ramp_sh_reg[i] <= cmd_wdata; // RQ14
            else if (sel && cmd_code == CMD_TOFF_RAMP)
                off_ramp_sh_reg[i] <= cmd_wdata; // RQ14
        end

        // Active ramps copied on commit
        always_ff @(posedge sys_clk)
        begin
            if (sys_rst)
            begin
                on_ramp_act_reg[i] <= RST_TON_RAMP;
                off_ramp_act_reg[i] <= RST_TOFF_RAMP;
            end
            else if (commit_settings_command) // RQ5 RQ8
            begin
                on_ramp_act_reg[i] <= on_ramp_sh_reg[i]; // RQ14
                off_ramp_act_reg[i] <= off_ramp_sh_reg[i]; // RQ14
            end
        end

        // Feed the sequencer
        assign link.enable = out_enable[i];
        assign link.on_delay = on_delay_reg[i];
        assign link.on_ramp = on_ramp_act_reg[i];
        assign link.off_delay = off_delay_reg[i];
        assign link.off_ramp = off_ramp_act_reg[i];
        assign powered[i] = link.powered;
        assign rising[i] = link.state == SEQ_RISE;
        assign falling[i] = link.state == SEQ_FALL;

        psf_seq u_seq (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .link(link)
        );
    end

    // ****************************************************************
    // Fault summary
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst) comm_memory_logic_flag_reg <= 1'b0;
        else if (bad_go) comm_memory_logic_flag_reg <= 1'b1; // RQ12
        else if (clear_faults) comm_memory_logic_flag_reg <= 1'b0;
    end

    psf_fault u_fault (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .powered(powered),
        .ov(output_overvoltage_flag),
        .oc(output_overcurrent_flag),
        .vin_uv(input_undervoltage_flag),
        .temp(temperature_flag),
        .comm(comm_memory_logic_flag_reg),
        .other(other_status_flag),
        .summary_reg(summary)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb
    begin
        case (cmd_code)
            CMD_IIN_OC_LIMIT: rd_data_next = iin_oc_shadow_reg;
            CMD_ON_DLY: rd_data_next = on_delay_reg[cmd_page];
            CMD_TON_RAMP: rd_data_next = on_ramp_sh_reg[cmd_page];
            CMD_OFF_DLY: rd_data_next = off_delay_reg[cmd_page];
            CMD_TOFF_RAMP: rd_data_next = off_ramp_sh_reg[cmd_page];
            CMD_FAULT_SUMMARY: rd_data_next = {8'h00, summary}; // RQ9
            default: rd_data_next = 16'h0000;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= cmd_valid && !cmd_write;
            if (cmd_valid && !cmd_write) rd_data_reg <= rd_data_next;
        end
    end

    // Sequencer state outputs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            out_powered_reg <= 2'h0;
            out_rising_reg <= 2'h0;
            out_falling_reg <= 2'h0;
        end
        else
        begin
            out_powered_reg <= powered; // RQ13
            out_rising_reg <= rising;
            out_falling_reg <= falling;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_iin_over_max: assert property ( // RQ1
        cmd_valid && cmd_write && cmd_code == CMD_IIN_OC_LIMIT
        && cmd_wdata > IIN_OC_MAX |=> $stable(iin_oc_shadow_reg))
        else $error("limit above maximum was stored");
    a_iin_commit_only: assert property ( // RQ1
        !$stable(iin_oc_active_reg) |-> $past(commit_settings_command))
        else $error("active limit moved without commit");
    a_commit_copies: assert property ( // RQ14
        commit_settings_command |=> on_ramp_act_reg[0]
        == $past(on_ramp_sh_reg[0]) && off_ramp_act_reg[1]
        == $past(off_ramp_sh_reg[1]))
        else $error("commit did not copy ramp shadows");
    a_ramp_hold: assert property ( // RQ14
        !commit_settings_command |=> $stable(on_ramp_act_reg[1]))
        else $error("active ramp moved without commit");
    a_ton_floor: assert property ( // RQ3
        on_delay_reg[0] >= ON_DLY_MIN && on_delay_reg[1] >= ON_DLY_MIN)
        else $error("turn-on delay below floor");
    a_ramp_range: assert property ( // RQ4
        on_ramp_sh_reg[0] <= RAMP_MAX && on_ramp_sh_reg[1] <= RAMP_MAX)
        else $error("turn-on ramp out of range");
    a_toff_range: assert property ( // RQ6
        off_delay_reg[0] <= OFF_DLY_MAX && off_delay_reg[1]
        <= OFF_DLY_MAX)
        else $error("turn-off delay out of range");
    a_fall_range: assert property ( // RQ7
        off_ramp_sh_reg[0] <= RAMP_MAX && off_ramp_sh_reg[1] <= RAMP_MAX)
        else $error("turn-off ramp out of range");
    a_summary_read: assert property ( // RQ10
        cmd_valid && !cmd_write && cmd_code == CMD_FAULT_SUMMARY
        |=> rd_valid_reg && rd_data_reg[15:7] == 9'h000
        && rd_data_reg[7:0] == $past(summary))
        else $error("summary read wrong");
    a_off_bit: assert property ( // RQ10
        ##1 summary[FS_OFF] == $past(~&powered))
        else $error("off bit does not follow outputs");
    a_fault_bits: assert property ( // RQ11
        ##1 summary[FS_OV] == $past(|output_overvoltage_flag)
        && summary[FS_OC] == $past(|output_overcurrent_flag)
        && summary[FS_VIN_UV] == $past(input_undervoltage_flag))
        else $error("fault bits do not follow inputs");
    a_comm_flag: assert property ( // RQ12
        bad_go |=> comm_memory_logic_flag_reg ##1 summary[FS_COMM])
        else $error("refused command not flagged");
endmodule

// [dv/psf_host_model.sv]
// Purpose: Host model driving the command port
// Assumes: Requests change at the falling edge
// Notes: Reads wait a bounded number of cycles for the answer
`timescale 1ns/1ps
module psf_host_model
(
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic cmd_page,
    output logic [15:0] cmd_wdata,
    output logic commit_settings_command,
    input wire logic [15:0] rd_data_reg,
    input wire logic rd_valid_reg
);
    // Idle port at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_page = 1'b0;
        cmd_wdata = 16'h0000;
        commit_settings_command = 1'b0;
    end
    // One command pulse, released data inverted
    task automatic send(input logic w, input logic [7:0] c, input logic p,
        input logic [15:0] d);
        @(negedge sys_clk);
        {cmd_valid, cmd_write, cmd_code} = {1'b1, w, c};
        {cmd_page, cmd_wdata} = {p, d};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
    endtask
    // Read with a bounded wait for the answer
    task automatic rd(input logic [7:0] c, input logic p,
        output logic [15:0] d, output logic ok);
        send(1'b0, c, p, 16'h0000);
        ok = 1'b0;
        d = 16'h0000;
        for (int i = 0; i < 3 && !ok; i++)
        begin
            if (rd_valid_reg === 1'b1)
            begin
                d = rd_data_reg;
                ok = 1'b1;
            end
            else
                @(negedge sys_clk);
        end
    endtask
    // Commit pulse after ramp or limit changes
    task automatic commit();
        @(negedge sys_clk);
        commit_settings_command = 1'b1;
        @(negedge sys_clk);
        commit_settings_command = 1'b0;
    endtask
endmodule

// [dv/psf_regs_bench.sv]
// Purpose: Self-checking bench for the sequencing and fault registers
// Assumes: All inputs change at the falling edge
// Notes: Sequencer timing allows two cycles of slack
`timescale 1ns/1ps
module psf_regs_bench;
    import psf_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, cmd_write, cmd_page, commit_settings_command;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rd_data_reg, iin_oc_active_reg;
    logic rd_valid_reg, comm_memory_logic_flag_reg;
    logic clear_faults = 1'b0;
    logic [1:0] out_enable = 2'b00;
    logic [5:0] flt = 6'h00;
    logic [1:0] out_powered_reg, out_rising_reg, out_falling_reg;
    logic [5:0] seq_flags;
    assign seq_flags = {out_powered_reg, out_rising_reg, out_falling_reg};
    logic [7:0] rc [5] = '{CMD_IIN_OC_LIMIT, CMD_ON_DLY, CMD_TON_RAMP,
        CMD_OFF_DLY, CMD_TOFF_RAMP};
    logic [15:0] rv [5] = '{RST_IIN_OC_LIMIT, RST_ON_DLY, RST_TON_RAMP,
        RST_OFF_DLY, RST_TOFF_RAMP};
    logic [15:0] bad [5] = '{16'h0033, 16'h0013, 16'h2711, 16'h2711, 16'h2711};
    logic [15:0] good [5] = '{16'h0032, 16'h0014, 16'h2710, 16'h2710,
        16'h2710};
    int miscompares = 0;
    int compares = 0;
    int n;
    psf_regs psf_regs_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .commit_settings_command(commit_settings_command),
        .clear_faults(clear_faults), .out_enable(out_enable),
        .output_overvoltage_flag({flt[5], 1'b0}),
        .output_overcurrent_flag({1'b0, flt[4]}),
        .input_undervoltage_flag(flt[3]), .temperature_flag(flt[2]),
        .other_status_flag(flt[0]), .rd_data_reg(rd_data_reg),
        .rd_valid_reg(rd_valid_reg),
        .comm_memory_logic_flag_reg(comm_memory_logic_flag_reg),
        .iin_oc_active_reg(iin_oc_active_reg),
        .out_powered_reg(out_powered_reg), .out_rising_reg(out_rising_reg),
        .out_falling_reg(out_falling_reg));
    psf_host_model psf_host_model_inst (.sys_clk(sys_clk),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .commit_settings_command(commit_settings_command),
        .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg));
    // Free-running clock
    always #20 sys_clk = ~sys_clk;
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic near(input int e);
        compares++;
        if (n < e - 2 || n > e + 2)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, n, e);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input logic p,
        input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        psf_host_model_inst.rd(c, p, d, ok);
        if (ok !== 1'b1)
        begin
            miscompares++;
            report_and_stop();
        end
        chk(d, e);
    endtask
    task automatic wr(input logic [7:0] c, input logic p,
        input logic [15:0] d);
        psf_host_model_inst.send(1'b1, c, p, d);
    endtask
    task automatic clr();
        @(negedge sys_clk);
        clear_faults = 1'b1;
        @(negedge sys_clk);
        clear_faults = 1'b0;
        @(negedge sys_clk);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return out_rising_reg[0];
            1: return out_falling_reg[0];
            default: return out_rising_reg[1];
        endcase
    endfunction
    // Count falling edges until a sequencer flag reaches a level
    task automatic wait_bit(input int k, input logic lvl, input int lim);
        n = 0;
        while (pick(k) !== lvl)
        begin
            @(negedge sys_clk);
            n++;
            if (n > lim)
            begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rdc(rc[i], 1'b0, rv[i]);
            rdc(rc[i], 1'b1, rv[i]);
        end
        rdc(CMD_FAULT_SUMMARY, 1'b0, 16'h0040);
        wr(CMD_IIN_OC_LIMIT, 1'b0, 16'h0020);
        rdc(CMD_IIN_OC_LIMIT, 1'b0, 16'h0020);
        chk(iin_oc_active_reg, 16'h0032);
        psf_host_model_inst.commit();
        @(negedge sys_clk);
        chk(iin_oc_active_reg, 16'h0020);
        for (int i = 0; i < 5; i++)
        begin
            wr(rc[i], 1'b0, good[i]);
            rdc(rc[i], 1'b0, good[i]);
            chk(16'(comm_memory_logic_flag_reg), 16'h0000);
            wr(rc[i], 1'b0, bad[i]);
            rdc(rc[i], 1'b0, good[i]);
            chk(16'(comm_memory_logic_flag_reg), 16'h0001);
            clr();
        end
        wr(CMD_FAULT_SUMMARY, 1'b0, 16'h00FF);
        rdc(CMD_FAULT_SUMMARY, 1'b0, 16'h0042);
        clr();
        rdc(8'h00, 1'b0, 16'h0000);
        chk(16'(comm_memory_logic_flag_reg), 16'h0001);
        clr();
        for (int k = 0; k < 6; k++)
        begin
            if (k == 1)
                continue;
            flt = 6'(1 << k);
            rdc(CMD_FAULT_SUMMARY, 1'b0, 16'h0040 | 16'(1 << k));
        end
        flt = 6'h00;
        wr(CMD_TON_RAMP, 1'b0, 16'h0004);
        wr(CMD_OFF_DLY, 1'b0, 16'h0001);
        wr(CMD_TOFF_RAMP, 1'b0, 16'h0002);
        psf_host_model_inst.commit();
        out_enable = 2'b11;
        wait_bit(0, 1'b1, 6000);
        near(int'(RST_ON_DLY) * DELAY_UNIT_US * CYC_PER_US + 3);
        wait_bit(0, 1'b0, 200);
        near(4 * CYC_PER_US + 1);
        wait_bit(2, 1'b0, 13000);
        near(int'(RST_TON_RAMP - 16'h0004) * CYC_PER_US);
        chk(16'(seq_flags), 16'h0030);
        rdc(CMD_FAULT_SUMMARY, 1'b0, 16'h0000);
        out_enable = 2'b10;
        wait_bit(1, 1'b1, 400);
        near(DELAY_UNIT_US * CYC_PER_US + 3);
        wait_bit(1, 1'b0, 100);
        near(2 * CYC_PER_US + 1);
        chk(16'(seq_flags), 16'h0020);
        rdc(CMD_FAULT_SUMMARY, 1'b0, 16'h0040);
        report_and_stop();
    end
endmodule
